// ---- rtl/iwr_top.v ----
// Independent watchdog: APB registers, key commands, update path and down-counter.
`timescale 1ns/10ps
`include "iwr_map.vh"

// Behaviour
// - Unlock code opens divider and reload writes
// - Start code starts the down-counter
// - Hardware mode runs already; start still accepted
// - Divider select picks ratio 4 to 256
// - Refresh loads reload value into counter
// - Timeout is reload times divide ratio
// - Reload field twelve bits, resets all ones
// - Counter from 0xFFF; reset at zero
// - Any other key relocks the registers
// - Pending flags track carrying new values
// - Hardware watchdog option starts at power-on
module iwr_top
(
    // Clock and reset.
    input wire sys_clk,
    input wire sys_rst,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Oscillator and power-on option.
    input wire low_speed_oscillator,
    input wire hw_watchdog_select,
    // Results.
    output reg watchdog_reset_out,
    output reg irq
);

wire osc_level;
wire count_tick;
reg osc_level_d;
reg osc_tick;
reg strap_taken;
reg hw_mode;
reg running;
reg unlocked;
reg [`IWR_RELOAD_W-1:0] counter;
reg [`IWR_DIV_W-1:0] div_shadow;
reg [`IWR_DIV_W-1:0] div_active;
reg div_pending;
reg [1:0] div_ticks;
reg [`IWR_RELOAD_W-1:0] reload_shadow;
reg [`IWR_RELOAD_W-1:0] reload_active;
reg reload_pending;
reg [1:0] reload_ticks;
reg [`IWR_INT_W-1:0] int_status;
reg [`IWR_INT_W-1:0] int_mask;
reg [`IWR_INT_W-1:0] int_set;
reg [`IWR_INT_W-1:0] next_int_status;
reg [31:0] next_prdata;
reg next_pslverr;
reg div_done;
reg reload_done;

wire bus_write = psel & penable & pready & pwrite;
wire key_write = bus_write & (paddr == `IWR_OFF_KEY) & pstrb[0] & pstrb[1];
wire [15:0] key_value = pwdata[15:0];
wire cmd_refresh = key_write & (key_value == `IWR_KEY_REFRESH);
wire cmd_unlock = key_write & (key_value == `IWR_KEY_UNLOCK);
wire cmd_start = key_write & (key_value == `IWR_KEY_START);
wire div_write = bus_write & (paddr == `IWR_OFF_DIV) & unlocked & pstrb[0];
wire reload_write = bus_write & (paddr == `IWR_OFF_RELOAD) & unlocked;

// True when the address names one of the mapped registers.
function addr_mapped;
    input [7:0] addr;
    begin
        case (addr)
            `IWR_OFF_KEY, `IWR_OFF_DIV, `IWR_OFF_RELOAD, `IWR_OFF_STATUS,
            `IWR_OFF_INT_STATUS, `IWR_OFF_INT_MASK, `IWR_OFF_COUNTER: addr_mapped = 1'b1;
            default: addr_mapped = 1'b0;
        endcase
    end
endfunction

iwr_sync u_osc_sync
(
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in(low_speed_oscillator),
    .sync_out(osc_level)
);

// Rising edges of the synchronised oscillator become one-cycle ticks.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        osc_level_d <= 1'b0;
        osc_tick <= 1'b0;
    end
    else
    begin
        osc_level_d <= osc_level;
        osc_tick <= osc_level & ~osc_level_d;
    end
end

// Ratio from the active divider select.
iwr_prescaler #(.DIV_W(`IWR_DIV_W)) u_prescaler
(
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .osc_tick(osc_tick),
    .divider_select(div_active),
    .count_tick(count_tick)
);

// Power-on option caught once after reset release.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        strap_taken <= 1'b0;
        hw_mode <= 1'b0;
    end
    else if (!strap_taken)
    begin
        strap_taken <= 1'b1;
        hw_mode <= hw_watchdog_select;
    end
end

// Unlock state: only the unlock code opens, every other key closes.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        unlocked <= 1'b0;
    end
    else if (key_write)
    begin
        unlocked <= cmd_unlock;
    end
end

// Divider update: the bus copy is held and moved to the active copy after three ticks.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        div_shadow <= `IWR_DIV_RESET;
        div_active <= `IWR_DIV_RESET;
        div_pending <= 1'b0;
        div_ticks <= 2'h0;
        div_done <= 1'b0;
    end
    else
    begin
        div_done <= 1'b0;
        if (div_write)
        begin
            div_shadow <= pwdata[`IWR_DIV_W-1:0];
            div_pending <= 1'b1;
            div_ticks <= 2'h0;
        end
        else if (div_pending && osc_tick)
        begin
            if (div_ticks == `IWR_UPDATE_TICKS - 2'h1)
            begin
                div_active <= div_shadow;
                div_pending <= 1'b0;
                div_done <= 1'b1;
            end
            else
            begin
                div_ticks <= div_ticks + 2'h1;
            end
        end
    end
end

// Reload update follows the same path; written byte lanes merge with the active copy into the bus copy.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        reload_shadow <= `IWR_RELOAD_RESET;
        reload_active <= `IWR_RELOAD_RESET;
        reload_pending <= 1'b0;
        reload_ticks <= 2'h0;
        reload_done <= 1'b0;
    end
    else
    begin
        reload_done <= 1'b0;
        if (reload_write && (pstrb[0] || pstrb[1]))
        begin
            reload_shadow <= {pstrb[1] ? pwdata[11:8] : reload_active[11:8],
                              pstrb[0] ? pwdata[7:0] : reload_active[7:0]};
            reload_pending <= 1'b1;
            reload_ticks <= 2'h0;
        end
        else if (reload_pending && osc_tick)
        begin
            if (reload_ticks == `IWR_UPDATE_TICKS - 2'h1)
            begin
                reload_active <= reload_shadow;
                reload_pending <= 1'b0;
                reload_done <= 1'b1;
            end
            else
            begin
                reload_ticks <= reload_ticks + 2'h1;
            end
        end
    end
end

// Run state and down-counter; once expired only sys_rst brings it back.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        running <= 1'b0;
        counter <= `IWR_RELOAD_RESET;
        watchdog_reset_out <= 1'b0;
    end
    else
    begin
        if (cmd_start || (strap_taken && hw_mode))
        begin
            running <= 1'b1;
        end
        if (cmd_refresh)
        begin
            counter <= reload_active;
        end
        else if (running && count_tick && counter != `IWR_COUNT_END)
        begin
            counter <= counter - 12'h001;
        end
        if (running && counter == `IWR_COUNT_END && !cmd_refresh)
        begin
            watchdog_reset_out <= 1'b1;
        end
    end
end

// Interrupt events: expiry, refresh seen and the two completed updates.
always @*
begin
    int_set = {`IWR_INT_W{1'b0}};
    int_set[`IWR_INT_TIMEOUT] = running & (counter == `IWR_COUNT_END) & ~watchdog_reset_out;
    int_set[`IWR_INT_REFRESH] = cmd_refresh;
    int_set[`IWR_INT_DIV_DONE] = div_done;
    int_set[`IWR_INT_RELOAD_DONE] = reload_done;
    next_int_status = int_status;
    if (bus_write && paddr == `IWR_OFF_INT_STATUS && pstrb[0])
    begin
        next_int_status = int_status & ~pwdata[`IWR_INT_W-1:0];
    end
    // A new event in the clearing cycle still lands.
    next_int_status = next_int_status | int_set;
end

// Sticky status, mask and the registered interrupt line.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        int_status <= {`IWR_INT_W{1'b0}};
        int_mask <= {`IWR_INT_W{1'b0}};
        irq <= 1'b0;
    end
    else
    begin
        int_status <= next_int_status;
        if (bus_write && paddr == `IWR_OFF_INT_MASK && pstrb[0])
        begin
            int_mask <= pwdata[`IWR_INT_W-1:0];
        end
        irq <= |(next_int_status & int_mask);
    end
end

// Read mux, evaluated in the setup cycle so data stand through the access cycle.
always @*
begin
    next_prdata = 32'h0000_0000;
    next_pslverr = ~addr_mapped(paddr);
    case (paddr)
        `IWR_OFF_DIV: next_prdata[`IWR_DIV_W-1:0] = div_active;
        `IWR_OFF_RELOAD: next_prdata[`IWR_RELOAD_W-1:0] = reload_active;
        `IWR_OFF_STATUS:
        begin
            next_prdata[`IWR_ST_DIV_PEND] = div_pending;
            next_prdata[`IWR_ST_RELOAD_PEND] = reload_pending;
        end
        `IWR_OFF_INT_STATUS: next_prdata[`IWR_INT_W-1:0] = int_status;
        `IWR_OFF_INT_MASK: next_prdata[`IWR_INT_W-1:0] = int_mask;
        `IWR_OFF_COUNTER:
        begin
            next_prdata[`IWR_RELOAD_W-1:0] = counter;
            next_prdata[`IWR_CNT_RUNNING] = running;
            next_prdata[`IWR_CNT_EXPIRED] = watchdog_reset_out;
        end
        default: next_prdata = 32'h0000_0000;
    endcase
end

// APB answer: one registered ready per transfer, raised in the access cycle.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end
    else
    begin
        pready <= psel & ~penable;
        if (psel && !penable)
        begin
            pslverr <= next_pslverr;
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end
        else
        begin
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
    end
end

endmodule

// ---- rtl/iwr_map.vh ----
// Register offsets, field positions, reset values and command codes of the watchdog registers.
`ifndef IWR_MAP_VH
`define IWR_MAP_VH

// Register byte offsets.
`define IWR_OFF_KEY 8'h00
`define IWR_OFF_DIV 8'h04
`define IWR_OFF_RELOAD 8'h08
`define IWR_OFF_STATUS 8'h0C
`define IWR_OFF_INT_STATUS 8'h10
`define IWR_OFF_INT_MASK 8'h14
`define IWR_OFF_COUNTER 8'h18

// Key command codes in the low half-word of the key register.
`define IWR_KEY_REFRESH 16'hAAAA
`define IWR_KEY_UNLOCK 16'h5555
`define IWR_KEY_START 16'hCCCC

// Field widths and reset values.
`define IWR_DIV_W 3
`define IWR_RELOAD_W 12
`define IWR_DIV_RESET 3'h0
`define IWR_RELOAD_RESET 12'hFFF
`define IWR_COUNT_END 12'h000

// Status register bit positions.
`define IWR_ST_DIV_PEND 0
`define IWR_ST_RELOAD_PEND 1

// Interrupt status and mask bit positions.
`define IWR_INT_W 4
`define IWR_INT_TIMEOUT 0
`define IWR_INT_REFRESH 1
`define IWR_INT_DIV_DONE 2
`define IWR_INT_RELOAD_DONE 3

// Counter readout bit positions.
`define IWR_CNT_RUNNING 16
`define IWR_CNT_EXPIRED 17

// Oscillator ticks needed to carry a new value into the counting logic.
`define IWR_UPDATE_TICKS 2'h3

`endif

// ---- rtl/iwr_sync.v ----
// Two-stage level synchroniser for the low-speed oscillator input.
`timescale 1ns/10ps
module iwr_sync
(
    // Clock and reset.
    input wire sys_clk,
    input wire sys_rst,
    // Level in and synchronised level out.
    input wire async_in,
    output reg sync_out
);

reg stage_one;

// The first stage feeds only the second, so metastability never spreads.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        stage_one <= 1'b0;
        sync_out <= 1'b0;
    end
    else
    begin
        stage_one <= async_in;
        sync_out <= stage_one;
    end
end

endmodule

// ---- rtl/iwr_prescaler.v ----
// Programmable divider that turns oscillator ticks into counter ticks.
`timescale 1ns/10ps
module iwr_prescaler
#(
    parameter DIV_W = 3
)
(
    // Clock and reset.
    input wire sys_clk,
    input wire sys_rst,
    // Oscillator tick and ratio select.
    input wire osc_tick,
    input wire [DIV_W-1:0] divider_select,
    // One-cycle pulse per divided period.
    output reg count_tick
);

reg [7:0] div_count;

// Terminal count for a select: (4 << sel) - 1, with the two top codes both at 255.
function [7:0] last_count;
    input [DIV_W-1:0] sel;
    begin
        case (sel)
            3'h0: last_count = 8'h03;
            3'h1: last_count = 8'h07;
            3'h2: last_count = 8'h0F;
            3'h3: last_count = 8'h1F;
            3'h4: last_count = 8'h3F;
            3'h5: last_count = 8'h7F;
            default: last_count = 8'hFF;
        endcase
    end
endfunction

// A shorter ratio taken mid-period ends the period at once rather than wrapping.
always @(posedge sys_clk or posedge sys_rst)
begin
    if (sys_rst)
    begin
        div_count <= 8'h00;
        count_tick <= 1'b0;
    end
    else
    begin
        count_tick <= 1'b0;
        if (osc_tick)
        begin
            if (div_count >= last_count(divider_select))
            begin
                div_count <= 8'h00;
                count_tick <= 1'b1;
            end
            else
            begin
                div_count <= div_count + 8'h01;
            end
        end
    end
end

endmodule

// ---- verification/iwr_top_properties.sv ----
// Checker for the watchdog register block, bound to its top module.
`timescale 1ns/10ps
module iwr_top_props
(
    // Clock and reset.
    input wire sys_clk,
    input wire sys_rst,
    // APB slave.
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // Oscillator, option and results.
    input wire low_speed_oscillator,
    input wire hw_watchdog_select,
    input wire watchdog_reset_out,
    input wire irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire rd_setup = psel && !penable && !pwrite;
    // The slave answers with no wait states, so a late pready is a fault.
    property p_ready_after; psel && !penable |=> pready; endproperty
    a_ready_after: assert property (p_ready_after) else $error("no pready");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long pready");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("lone pslverr");
    property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle prdata");
    property p_key_zero; rd_setup && paddr == 8'h00 |=> prdata == 32'h0; endproperty
    a_key_zero: assert property (p_key_zero) else $error("key read");
    property p_div_res; rd_setup && paddr == 8'h04 |=> prdata[31:3] == 29'h0; endproperty
    a_div_res: assert property (p_div_res) else $error("divider bits");
    property p_rel_res; rd_setup && paddr == 8'h08 |=> prdata[31:12] == 20'h0; endproperty
    a_rel_res: assert property (p_rel_res) else $error("reload bits");
    property p_st_res; rd_setup && paddr == 8'h0C |=> prdata[31:2] == 30'h0; endproperty
    a_st_res: assert property (p_st_res) else $error("status bits");
    property p_unmapped; psel && !penable && paddr > 8'h18 |=> pslverr && prdata == 0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    property p_sticky; watchdog_reset_out |=> watchdog_reset_out; endproperty
    a_sticky: assert property (p_sticky) else $error("reset dropped");
endmodule
bind iwr_top iwr_top_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .low_speed_oscillator(low_speed_oscillator), .hw_watchdog_select(hw_watchdog_select),
    .watchdog_reset_out(watchdog_reset_out), .irq(irq));

// ---- verification/independent_watchdog_regs_test.sv ----
// Self-checking bench for the watchdog register block.
`timescale 1ns/10ps
`include "iwr_map.vh"
module independent_watchdog_regs_test;
    reg sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    reg [7:0] paddr = 0;
    reg [31:0] pwdata = 0, rd;
    reg [3:0] pstrb = 4'hF;
    reg low_speed_oscillator = 0, hw_watchdog_select = 0, err;
    wire [31:0] prdata;
    wire pready, pslverr, watchdog_reset_out, irq;
    integer fail_count = 0, n_compared = 0, seed = 32'h6281, cyc = 0, osc = 0, ticks = 0;
    integer i, n, t, m_rel;
    iwr_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .low_speed_oscillator(low_speed_oscillator),
        .hw_watchdog_select(hw_watchdog_select), .watchdog_reset_out(watchdog_reset_out),
        .irq(irq));
    // Clock of 100 ns period.
    always #50 sys_clk = ~sys_clk;
    // Fast oscillator toggling every two clocks; its rising edges are counted.
    always @(posedge sys_clk)
    begin
        osc <= osc + 1;
        cyc <= cyc + 1;
        if (osc % 2 == 1)
            low_speed_oscillator <= ~low_speed_oscillator;
        if (osc % 2 == 1 && !low_speed_oscillator)
            ticks <= ticks + 1;
        if (cyc == 60000)
        begin
            fail_count = fail_count + 1;
            tally_and_finish;
        end
    end
    task tally_and_finish;
    begin
        if (fail_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    end
    endtask
    // One APB transfer; holds the request until pready is sampled high.
    task apb(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge sys_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task rdchk(input [7:0] a, input [31:0] exp);
    begin
        apb(0, a, 0);
        chk(rd, exp);
    end
    endtask
    // Polls the status register until both pending flags clear.
    task wait_pend;
    begin
        for (t = 0; t < 40; t = t + 1)
        begin
            apb(0, `IWR_OFF_STATUS, 0);
            if (rd[1:0] === 2'h0)
                t = 99;
        end
        // An exhausted poll counts as a mismatch rather than passing silently.
        if (t != 100)
            chk(rd[1:0], 0);
    end
    endtask
    task do_reset(input hw);
    begin
        sys_rst <= 1;
        hw_watchdog_select <= hw;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 0;
        m_rel = 32'hFFF;
    end
    endtask
    // Main sequence: registers, lock, pending, then each divide ratio.
    initial
    begin
        do_reset(0);
        rdchk(`IWR_OFF_KEY, 0);
        rdchk(`IWR_OFF_DIV, 0);
        rdchk(`IWR_OFF_RELOAD, m_rel);
        rdchk(`IWR_OFF_STATUS, 0);
        apb(0, 8'h1C, 0);
        chk(err, 1);
        apb(1, `IWR_OFF_RELOAD, 32'h123);
        wait_pend;
        rdchk(`IWR_OFF_RELOAD, m_rel);
        apb(1, `IWR_OFF_KEY, `IWR_KEY_UNLOCK);
        n = $random(seed);
        m_rel = n & 32'hFFF;
        apb(1, `IWR_OFF_RELOAD, n);
        rdchk(`IWR_OFF_STATUS, 2);
        wait_pend;
        rdchk(`IWR_OFF_RELOAD, m_rel);
        // Only byte lane 0 is written, so the upper nibble keeps the applied value.
        pstrb <= 4'h1;
        apb(1, `IWR_OFF_RELOAD, 32'hABC);
        pstrb <= 4'hF;
        wait_pend;
        m_rel = (m_rel & 32'hF00) | 32'hBC;
        rdchk(`IWR_OFF_RELOAD, m_rel);
        apb(1, `IWR_OFF_KEY, `IWR_KEY_REFRESH);
        apb(1, `IWR_OFF_RELOAD, 0);
        wait_pend;
        rdchk(`IWR_OFF_RELOAD, m_rel);
        pstrb <= 4'h4;
        apb(1, `IWR_OFF_KEY, `IWR_KEY_START);
        pstrb <= 4'hF;
        rdchk(`IWR_OFF_COUNTER, m_rel);
        for (i = 0; i < 8; i = i + 1)
        begin
            do_reset(i == 7);
            apb(1, `IWR_OFF_KEY, `IWR_KEY_UNLOCK);
            apb(1, `IWR_OFF_DIV, i);
            apb(1, `IWR_OFF_RELOAD, 3);
            wait_pend;
            rdchk(`IWR_OFF_DIV, i);
            apb(0, `IWR_OFF_COUNTER, 0);
            chk(rd[16], i == 7);
            apb(1, `IWR_OFF_KEY, `IWR_KEY_START);
            apb(0, `IWR_OFF_COUNTER, 0);
            if (i < 7)
                chk(rd[16] && rd[11:0] >= 12'hFFE, 1);
            apb(1, `IWR_OFF_KEY, `IWR_KEY_REFRESH);
            t = ticks;
            for (n = 0; n < 4000 && watchdog_reset_out !== 1'b1; n = n + 1)
                @(posedge sys_clk);
            n = (i > 5) ? 256 : (4 << i);
            t = ticks - t;
            chk(t > 2 * n && t <= 3 * n + 2, 1);
        end
        apb(0, `IWR_OFF_INT_STATUS, 0);
        chk(rd[`IWR_INT_TIMEOUT], 1);
        chk(rd[3:1], 3'h7);
        chk(irq, 0);
        apb(1, `IWR_OFF_INT_MASK, 1);
        rdchk(`IWR_OFF_INT_MASK, 1);
        chk(irq, 1);
        apb(1, `IWR_OFF_INT_STATUS, 1);
        rdchk(`IWR_OFF_INT_MASK, 1);
        chk(irq, 0);
        chk(watchdog_reset_out, 1);
        tally_and_finish;
    end
endmodule
